// ---- hw/gcp_pkg.sv ----
// Package for the global configuration and pull reference register bank.
// Assumes a single AHB-Lite slave port decoding the low 12 address bits, upper address bits zero.
package gcp_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam int unsigned GCP_ADDR_W          = 12;
    localparam logic [11:0] GCP_OFS_ERR_STATUS  = 12'h388;
    localparam logic [11:0] GCP_OFS_DIO_STATUS  = 12'h38c;
    localparam logic [11:0] GCP_OFS_GLOBAL_CFG  = 12'h398;
    localparam logic [11:0] GCP_OFS_DIO_PULL    = 12'h39c;
    localparam logic [11:0] GCP_OFS_REAR_PULL   = 12'h3a0;
    localparam logic [11:0] GCP_OFS_ERR_ENABLE  = 12'h3b0;
    localparam logic [11:0] GCP_OFS_DIO_ENABLE  = 12'h3b4;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int unsigned GCP_ENDIAN_BIT      = 0;
    localparam int unsigned GCP_ACK_MODE_BIT    = 1;
    localparam int unsigned GCP_PULL_LSB        = 0;
    localparam int unsigned GCP_PULL_W          = 2;
    localparam logic        GCP_ENDIAN_RST      = 1'h0;
    localparam logic        GCP_ACK_MODE_RST    = 1'h0;
    localparam logic [1:0]  GCP_PULL_RST        = 2'h0;
    localparam int unsigned GCP_ERR_W_DEF       = 4;
    localparam int unsigned GCP_DIO_W_DEF       = 20;
    localparam int unsigned GCP_SAMPLE_W        = 16;

    // ************************************************************
    // Pull reference codes and bus encodings
    // ************************************************************
    localparam logic [1:0]  GCP_PULL_FLOAT      = 2'h0;
    localparam logic [1:0]  GCP_PULL_5V         = 2'h1;
    localparam logic [1:0]  GCP_PULL_3V3        = 2'h2;
    localparam logic [1:0]  GCP_PULL_GND        = 2'h3;
    localparam logic        GCP_ACK_WRITE       = 1'h0;
    localparam logic        GCP_ACK_READ        = 1'h1;
    localparam logic [2:0]  GCP_HSIZE_WORD      = 3'h2;
    localparam logic        GCP_HRESP_OKAY      = 1'h0;

    // Register selected by an address phase
    typedef enum logic [2:0] {
        GCP_SEL_NONE,
        GCP_SEL_ERR_STATUS,
        GCP_SEL_DIO_STATUS,
        GCP_SEL_GLOBAL_CFG,
        GCP_SEL_DIO_PULL,
        GCP_SEL_REAR_PULL,
        GCP_SEL_ERR_ENABLE,
        GCP_SEL_DIO_ENABLE
    } gcp_sel_t;

    // Data phase state of the bus slave
    typedef enum logic [1:0] {
        GCP_DPH_IDLE,
        GCP_DPH_WRITE,
        GCP_DPH_RD_WAIT,
        GCP_DPH_RD_DONE
    } gcp_dph_t;

endpackage

// ---- hw/gcp_status_unit.sv ----
// One sticky interrupt status register with per-bit enables.
// Assumes the caller computes the clear mask for the chosen ack mode.
`timescale 1ns/100ps

module gcp_status_unit #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             ref_clk_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] event_i,
    input  wire logic [WIDTH-1:0] enable_i,
    input  wire logic [WIDTH-1:0] clear_i,
    output logic      [WIDTH-1:0] status_o
);

    // ************************************************************
    // Parameter check
    // ************************************************************
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("gcp_status_unit: WIDTH must be 1 to 32");
    end

    typedef struct packed {
        logic [WIDTH-1:0] status;
    } gcp_stat_state_t;

    gcp_stat_state_t st_r;
    gcp_stat_state_t st_nxt;

    // ************************************************************
    // Next state
    // ************************************************************
    // Set beats clear: event in a clearing cycle stays
    always_comb begin
        st_nxt        = st_r;
        st_nxt.status = (st_r.status & ~clear_i)
                      | (event_i & enable_i);
    end

    // Register update
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign status_o = st_r.status;

endmodule // gcp_status_unit

// ---- hw/gcp_regs.sv ----
// Global configuration and pull reference register bank, AHB-Lite slave.
// Assumes one bus master, hready fed back from hreadyout, word accesses.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/100ps

// Behaviour
// - Config bit 1 picks ack mode, reset 0
// - Write-clear mode: written ones clear status bits
// - Read-clear mode: read returns then clears bits
// - Config bit 0 picks DMA byte order
// - Order bit 0: low byte first
// - Order bit 1: high byte first
// - Digital line pull field, bits 1:0
// - Digital line pull resets to floating
// - Rear connector pull field, same coding
// - Pull codes driven to board switches
// - Enabled events set sticky status bits
module gcp_regs #(
    parameter int unsigned ERR_W = gcp_pkg::GCP_ERR_W_DEF,
    parameter int unsigned DIO_W = gcp_pkg::GCP_DIO_W_DEF
) (
    input  wire logic                            ref_clk_i,
    input  wire logic                            resetn_i,
    // AHB-Lite slave
    input  wire logic                            hsel_i,
    input  wire logic [31:0]                     haddr_i,
    input  wire logic [1:0]                      htrans_i,
    input  wire logic                            hwrite_i,
    input  wire logic [2:0]                      hsize_i,
    input  wire logic [31:0]                     hwdata_i,
    input  wire logic                            hready_i,
    output logic      [31:0]                     hrdata_o,
    output logic                                 hreadyout_o,
    output logic                                 hresp_o,
    // Interrupt sources
    input  wire logic [ERR_W-1:0]                err_event_i,
    input  wire logic [DIO_W-1:0]                dio_event_i,
    // DMA sample path
    input  wire logic [gcp_pkg::GCP_SAMPLE_W-1:0] dma_sample_i,
    input  wire logic                            dma_sample_valid_i,
    output logic      [gcp_pkg::GCP_SAMPLE_W-1:0] dma_host_data_o,
    output logic                                 dma_host_valid_o,
    // Board pull reference switching
    output logic      [1:0]                      digital_line_pull_ref_o,
    output logic      [1:0]                      rear_connector_pull_ref_o
);

    // ************************************************************
    // Parameter checks
    // ************************************************************
    if (ERR_W < 1 || ERR_W > 32) begin : g_bad_err_w
        $error("gcp_regs: ERR_W must be 1 to 32");
    end
    if (DIO_W < 1 || DIO_W > 32) begin : g_bad_dio_w
        $error("gcp_regs: DIO_W must be 1 to 32");
    end

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Address to register select
    function automatic gcp_pkg::gcp_sel_t gcp_decode(
        input logic [31:0] addr
    );
        logic [gcp_pkg::GCP_ADDR_W-1:0] ofs;
        gcp_pkg::gcp_sel_t              sel;
        ofs = addr[gcp_pkg::GCP_ADDR_W-1:0];
        sel = gcp_pkg::GCP_SEL_NONE;
        if (addr[31:gcp_pkg::GCP_ADDR_W] == '0) begin
            case (ofs)
                gcp_pkg::GCP_OFS_ERR_STATUS: sel = gcp_pkg::GCP_SEL_ERR_STATUS;
                gcp_pkg::GCP_OFS_DIO_STATUS: sel = gcp_pkg::GCP_SEL_DIO_STATUS;
                gcp_pkg::GCP_OFS_GLOBAL_CFG: sel = gcp_pkg::GCP_SEL_GLOBAL_CFG;
                gcp_pkg::GCP_OFS_DIO_PULL:   sel = gcp_pkg::GCP_SEL_DIO_PULL;
                gcp_pkg::GCP_OFS_REAR_PULL:  sel = gcp_pkg::GCP_SEL_REAR_PULL;
                gcp_pkg::GCP_OFS_ERR_ENABLE: sel = gcp_pkg::GCP_SEL_ERR_ENABLE;
                gcp_pkg::GCP_OFS_DIO_ENABLE: sel = gcp_pkg::GCP_SEL_DIO_ENABLE;
                default:                     sel = gcp_pkg::GCP_SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // Host byte order; bits 7:0 at lower address
    function automatic logic [gcp_pkg::GCP_SAMPLE_W-1:0] gcp_order(
        input logic [gcp_pkg::GCP_SAMPLE_W-1:0] smp,
        input logic                             big
    );
        logic [gcp_pkg::GCP_SAMPLE_W-1:0] res;
        res = smp;
        if (big) begin
            res = {smp[7:0], smp[15:8]};
        end
        return res;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        gcp_pkg::gcp_dph_t               dph;
        gcp_pkg::gcp_sel_t               sel;
        logic                            ack_mode;
        logic                            endian;
        logic [1:0]                      dio_pull;
        logic [1:0]                      rear_pull;
        logic [ERR_W-1:0]                err_en;
        logic [DIO_W-1:0]                dio_en;
        logic [31:0]                     rdata;
        logic [gcp_pkg::GCP_SAMPLE_W-1:0] dma_data;
        logic                            dma_valid;
    } gcp_state_t;

    gcp_state_t st_r;
    gcp_state_t st_nxt;

    // Status unit hookups
    logic [ERR_W-1:0] err_status;
    logic [DIO_W-1:0] dio_status;
    logic [ERR_W-1:0] err_clear;
    logic [DIO_W-1:0] dio_clear;

    // Bus qualifiers
    logic addr_take;
    logic wr_now;
    logic rd_now;

    // ************************************************************
    // Status registers
    // ************************************************************
    gcp_status_unit #(
        .WIDTH (ERR_W)
    ) u_err_status (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .event_i   (err_event_i),
        .enable_i  (st_r.err_en),
        .clear_i   (err_clear),
        .status_o  (err_status)
    );

    gcp_status_unit #(
        .WIDTH (DIO_W)
    ) u_dio_status (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .event_i   (dio_event_i),
        .enable_i  (st_r.dio_en),
        .clear_i   (dio_clear),
        .status_o  (dio_status)
    );

    // ************************************************************
    // Bus qualifiers
    // ************************************************************
    // Only whole-word transfers count
    assign addr_take = hsel_i & htrans_i[1] & hready_i
                     & (hsize_i == gcp_pkg::GCP_HSIZE_WORD);
    assign wr_now    = (st_r.dph == gcp_pkg::GCP_DPH_WRITE);
    assign rd_now    = (st_r.dph == gcp_pkg::GCP_DPH_RD_WAIT);

    // ************************************************************
    // Interrupt acknowledge
    // ************************************************************
    // Clear written ones, or what a read returned
    always_comb begin
        err_clear = '0;
        dio_clear = '0;
        if (st_r.ack_mode == gcp_pkg::GCP_ACK_WRITE) begin
            if (wr_now && st_r.sel == gcp_pkg::GCP_SEL_ERR_STATUS) begin
                err_clear = hwdata_i[ERR_W-1:0];
            end
            if (wr_now && st_r.sel == gcp_pkg::GCP_SEL_DIO_STATUS) begin
                dio_clear = hwdata_i[DIO_W-1:0];
            end
        end else begin
            if (rd_now && st_r.sel == gcp_pkg::GCP_SEL_ERR_STATUS) begin
                err_clear = err_status;
            end
            if (rd_now && st_r.sel == gcp_pkg::GCP_SEL_DIO_STATUS) begin
                dio_clear = dio_status;
            end
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;

        // Writes; reserved bits not stored
        if (wr_now) begin
            case (st_r.sel)
                gcp_pkg::GCP_SEL_GLOBAL_CFG: begin
                    st_nxt.ack_mode = hwdata_i[gcp_pkg::GCP_ACK_MODE_BIT];
                    st_nxt.endian   = hwdata_i[gcp_pkg::GCP_ENDIAN_BIT];
                end
                gcp_pkg::GCP_SEL_DIO_PULL: begin
                    st_nxt.dio_pull =
                        hwdata_i[gcp_pkg::GCP_PULL_LSB +: gcp_pkg::GCP_PULL_W];
                end
                gcp_pkg::GCP_SEL_REAR_PULL: begin
                    st_nxt.rear_pull =
                        hwdata_i[gcp_pkg::GCP_PULL_LSB +: gcp_pkg::GCP_PULL_W];
                end
                gcp_pkg::GCP_SEL_ERR_ENABLE: begin
                    st_nxt.err_en = hwdata_i[ERR_W-1:0];
                end
                gcp_pkg::GCP_SEL_DIO_ENABLE: begin
                    st_nxt.dio_en = hwdata_i[DIO_W-1:0];
                end
                default: begin
                    st_nxt.ack_mode = st_r.ack_mode;
                end
            endcase
        end

        // Data phase sequencing
        case (st_r.dph)
            gcp_pkg::GCP_DPH_RD_WAIT: begin
                // Read data sampled one cycle late so a write just before
                // is already visible; costs one wait state per read
                st_nxt.rdata = '0;
                case (st_r.sel)
                    gcp_pkg::GCP_SEL_ERR_STATUS:
                        st_nxt.rdata[ERR_W-1:0] = err_status;
                    gcp_pkg::GCP_SEL_DIO_STATUS:
                        st_nxt.rdata[DIO_W-1:0] = dio_status;
                    gcp_pkg::GCP_SEL_GLOBAL_CFG: begin
                        st_nxt.rdata[gcp_pkg::GCP_ACK_MODE_BIT] = st_r.ack_mode;
                        st_nxt.rdata[gcp_pkg::GCP_ENDIAN_BIT]   = st_r.endian;
                    end
                    gcp_pkg::GCP_SEL_DIO_PULL:
                        st_nxt.rdata[gcp_pkg::GCP_PULL_LSB +: gcp_pkg::GCP_PULL_W] =
                            st_r.dio_pull;
                    gcp_pkg::GCP_SEL_REAR_PULL:
                        st_nxt.rdata[gcp_pkg::GCP_PULL_LSB +: gcp_pkg::GCP_PULL_W] =
                            st_r.rear_pull;
                    gcp_pkg::GCP_SEL_ERR_ENABLE:
                        st_nxt.rdata[ERR_W-1:0] = st_r.err_en;
                    gcp_pkg::GCP_SEL_DIO_ENABLE:
                        st_nxt.rdata[DIO_W-1:0] = st_r.dio_en;
                    default:
                        st_nxt.rdata = '0;              // Unmapped reads zero
                endcase
                st_nxt.dph = gcp_pkg::GCP_DPH_RD_DONE;
            end
            gcp_pkg::GCP_DPH_IDLE,
            gcp_pkg::GCP_DPH_WRITE,
            gcp_pkg::GCP_DPH_RD_DONE: begin
                // hready is high here, so a new address phase may be taken
                if (addr_take) begin
                    st_nxt.sel = gcp_decode(haddr_i);
                    st_nxt.dph = hwrite_i ? gcp_pkg::GCP_DPH_WRITE
                                          : gcp_pkg::GCP_DPH_RD_WAIT;
                end else begin
                    st_nxt.sel = gcp_pkg::GCP_SEL_NONE;
                    st_nxt.dph = gcp_pkg::GCP_DPH_IDLE;
                end
            end
            default: begin
                st_nxt.dph = gcp_pkg::GCP_DPH_IDLE;
            end
        endcase

        // DMA reorder, one cycle
        st_nxt.dma_valid = dma_sample_valid_i;
        if (dma_sample_valid_i) begin
            st_nxt.dma_data = gcp_order(dma_sample_i, st_r.endian);
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            st_r.dph       <= gcp_pkg::GCP_DPH_IDLE;
            st_r.sel       <= gcp_pkg::GCP_SEL_NONE;
            st_r.ack_mode  <= gcp_pkg::GCP_ACK_MODE_RST;
            st_r.endian    <= gcp_pkg::GCP_ENDIAN_RST;
            st_r.dio_pull  <= gcp_pkg::GCP_PULL_RST;
            st_r.rear_pull <= gcp_pkg::GCP_PULL_RST;
            st_r.err_en    <= '0;
            st_r.dio_en    <= '0;
            st_r.rdata     <= '0;
            st_r.dma_data  <= '0;
            st_r.dma_valid <= 1'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Wait state in first read data cycle
    assign hreadyout_o = (st_r.dph != gcp_pkg::GCP_DPH_RD_WAIT);
    assign hresp_o     = gcp_pkg::GCP_HRESP_OKAY;
    assign hrdata_o    = st_r.rdata;

    // Board switching follows stored codes
    assign digital_line_pull_ref_o   = st_r.dio_pull;
    assign rear_connector_pull_ref_o = st_r.rear_pull;

    assign dma_host_data_o  = st_r.dma_data;
    assign dma_host_valid_o = st_r.dma_valid;

endmodule // gcp_regs

// ---- tb/gcp_regs_chk.sv ----
// Checker for the register bank: bus timing, pull outputs, DMA byte order.
// Assumes binding to gcp_regs, hready fed from hreadyout.
`timescale 1ns/100ps

module gcp_regs_chk #(
    parameter int unsigned ERR_W = 4,
    parameter int unsigned DIO_W = 20
) (
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [2:0]  hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic [15:0] dma_sample_i,
    input wire logic        dma_sample_valid_i,
    input wire logic [15:0] dma_host_data_o,
    input wire logic        dma_host_valid_o,
    input wire logic [1:0]  digital_line_pull_ref_o,
    input wire logic [1:0]  rear_connector_pull_ref_o
);
    // ************************************************************
    // Transfer decode
    // ************************************************************
    logic take_w;
    logic take_r;
    logic hit_dio;
    logic hit_rear;
    logic hit_cfg;
    logic wr_dio_r;
    logic wr_rear_r;
    assign take_w   = hsel_i & htrans_i[1] & hready_i & (hsize_i == 3'h2) & hwrite_i;
    assign take_r   = hsel_i & htrans_i[1] & hready_i & (hsize_i == 3'h2) & !hwrite_i;
    assign hit_dio  = haddr_i == {20'h0, gcp_pkg::GCP_OFS_DIO_PULL};
    assign hit_rear = haddr_i == {20'h0, gcp_pkg::GCP_OFS_REAR_PULL};
    assign hit_cfg  = haddr_i == {20'h0, gcp_pkg::GCP_OFS_GLOBAL_CFG};

    // Pull write awaiting data phase; held in stalls
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            wr_dio_r  <= 1'b0;
            wr_rear_r <= 1'b0;
        end else if (hreadyout_o) begin
            wr_dio_r  <= take_w & hit_dio;
            wr_rear_r <= take_w & hit_rear;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    // ************************************************************
    // Assertions
    // ************************************************************
    a_okay_resp: assert property (hresp_o == 1'b0)
        else $error("response not okay");
    a_read_one_wait: assert property (take_r |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (take_w |=> hreadyout_o)
        else $error("write stalled");
    a_rsvd_read_zero: assert property (
        take_r && (hit_cfg || hit_dio || hit_rear) |=> ##1 hrdata_o[31:2] == 30'h0)
        else $error("reserved bits not zero");
    a_dio_read_match: assert property (
        take_r && hit_dio |=> ##1 hrdata_o[1:0] == digital_line_pull_ref_o)
        else $error("digital pull readback differs");
    a_dio_pull_value: assert property (
        wr_dio_r && hreadyout_o |=> digital_line_pull_ref_o == $past(hwdata_i[1:0]))
        else $error("digital pull not written");
    a_dio_pull_hold: assert property (
        $changed(digital_line_pull_ref_o) |-> $past(wr_dio_r && hreadyout_o))
        else $error("digital pull moved alone");
    a_rear_pull_value: assert property (
        wr_rear_r && hreadyout_o |=> rear_connector_pull_ref_o == $past(hwdata_i[1:0]))
        else $error("rear pull not written");
    a_rear_pull_hold: assert property (
        $changed(rear_connector_pull_ref_o) |-> $past(wr_rear_r && hreadyout_o))
        else $error("rear pull moved alone");
    a_dma_valid_delay: assert property (dma_host_valid_o == $past(dma_sample_valid_i))
        else $error("dma valid delay wrong");
    a_dma_byte_order: assert property (dma_host_valid_o |->
        dma_host_data_o == $past(dma_sample_i) ||
        dma_host_data_o == {$past(dma_sample_i[7:0]), $past(dma_sample_i[15:8])})
        else $error("dma byte order wrong");

    // Main scenarios reached
    c_dio_write: cover property (wr_dio_r && hreadyout_o);
    c_cfg_read: cover property (take_r && hit_cfg);
    c_dma_swap: cover property (dma_host_valid_o && dma_host_data_o == 16'hefbe);
endmodule // gcp_regs_chk

bind gcp_regs gcp_regs_chk #(.ERR_W(ERR_W), .DIO_W(DIO_W)) gcp_regs_chk_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .dma_sample_i(dma_sample_i),
    .dma_sample_valid_i(dma_sample_valid_i), .dma_host_data_o(dma_host_data_o),
    .dma_host_valid_o(dma_host_valid_o), .digital_line_pull_ref_o(digital_line_pull_ref_o),
    .rear_connector_pull_ref_o(rear_connector_pull_ref_o));

// ---- tb/gcp_tb.sv ----
// Self-checking bench, AHB-Lite master in tasks.
// Assumes hreadyout fed back as hready.
`timescale 1ns/100ps

module tb;
    localparam int unsigned ERR_W = 4;
    localparam int unsigned DIO_W = 20;
    localparam logic [31:0] A_ERR  = {20'h0, gcp_pkg::GCP_OFS_ERR_STATUS};
    localparam logic [31:0] A_DIO  = {20'h0, gcp_pkg::GCP_OFS_DIO_STATUS};
    localparam logic [31:0] A_CFG  = {20'h0, gcp_pkg::GCP_OFS_GLOBAL_CFG};
    localparam logic [31:0] A_DPL  = {20'h0, gcp_pkg::GCP_OFS_DIO_PULL};
    localparam logic [31:0] A_RPL  = {20'h0, gcp_pkg::GCP_OFS_REAR_PULL};
    localparam logic [31:0] A_EEN  = {20'h0, gcp_pkg::GCP_OFS_ERR_ENABLE};
    localparam logic [31:0] A_DEN  = {20'h0, gcp_pkg::GCP_OFS_DIO_ENABLE};
    typedef struct packed { logic [31:0] a; logic [31:0] wd; logic [31:0] rd; } gcp_row_t;

    logic             clk = 1'b0;
    logic             resetn = 1'b0;
    logic             hsel = 1'b0;
    logic [31:0]      haddr = 32'h0;
    logic [1:0]       htrans = 2'h0;
    logic             hwrite = 1'b0;
    logic [2:0]       hsize = 3'h2;
    logic [31:0]      hwdata = 32'h0;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
    logic [ERR_W-1:0] err_ev = 4'h0;
    logic [DIO_W-1:0] dio_ev = 20'h0;
    logic [15:0]      smp = 16'h0;
    logic             smp_v = 1'b0;
    logic [15:0]      host_d;
    logic             host_v;
    logic [1:0]       dio_pull;
    logic [1:0]       rear_pull;
    int               errors = 0;
    int               n_checks = 0;
    // Reserved bits set in eight rows; unmapped last
    gcp_row_t rows [11] = '{
        '{A_CFG, 32'hffff_fffc, 32'h0}, '{A_CFG, 32'h0000_0003, 32'h3},
        '{A_CFG, 32'h0000_0000, 32'h0}, '{A_DPL, 32'hffff_fffc, 32'h0},
        '{A_DPL, 32'h5555_5551, 32'h1}, '{A_DPL, 32'haaaa_aaaa, 32'h2},
        '{A_RPL, 32'h1234_5671, 32'h1}, '{A_RPL, 32'h8000_0002, 32'h2},
        '{A_RPL, 32'h0000_0003, 32'h3}, '{32'h0000_03a4, 32'hffff_ffff, 32'h0},
        '{32'h0000_1398, 32'hffff_ffff, 32'h0}};

    always #2.5 clk = ~clk;

    gcp_regs #(.ERR_W(ERR_W), .DIO_W(DIO_W)) gcp_regs_inst (
        .ref_clk_i(clk), .resetn_i(resetn), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .err_event_i(err_ev), .dio_event_i(dio_ev), .dma_sample_i(smp),
        .dma_sample_valid_i(smp_v), .dma_host_data_o(host_d), .dma_host_valid_o(host_v),
        .digital_line_pull_ref_o(dio_pull), .rear_connector_pull_ref_o(rear_pull));

    // ************************************************************
    // Bus and compare tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Ready seen at the falling edge, as the next edge samples it
    task automatic wait_rdy(output logic [31:0] rd);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) errors++;
        rd = hrdata;
        @(posedge clk);
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy(rd);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(rd);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, a, wd, d);
    endtask

    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk(nm, exp, d);
    endtask

    // One-cycle event pulse
    task automatic ev(input logic [DIO_W-1:0] d, input logic [ERR_W-1:0] e);
        dio_ev <= d;
        err_ev <= e;
        @(posedge clk);
        dio_ev <= 20'h0;
        err_ev <= 4'h0;
        @(posedge clk);
    endtask

    task automatic dma(input logic [15:0] s, input logic [15:0] exp);
        smp <= s;
        smp_v <= 1'b1;
        @(posedge clk);
        smp_v <= 1'b0;
        @(negedge clk);
        chk("dma_data", {16'h0, exp}, {16'h0, host_d});
        chk("dma_valid", 32'h1, {31'h0, host_v});
        @(posedge clk);
    endtask

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk("dio_pull_o", 32'h0, {30'h0, dio_pull});
        chk("rear_pull_o", 32'h0, {30'h0, rear_pull});
        rd_chk("cfg", A_CFG, 32'h0);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        do_reset();
        rd_chk("dio_pull", A_DPL, 32'h0);
        rd_chk("rear_pull", A_RPL, 32'h0);
        for (int i = 0; i < 11; i++) begin
            wr(rows[i].a, rows[i].wd);
            rd_chk("row", rows[i].a, rows[i].rd);
            if (rows[i].a == A_DPL) chk("dio_pull_o", rows[i].rd, {30'h0, dio_pull});
            if (rows[i].a == A_RPL) chk("rear_pull_o", rows[i].rd, {30'h0, rear_pull});
        end
        wr(A_DPL, 32'h0000_0003);
        @(negedge clk);
        chk("dio_pull_o", 32'h3, {30'h0, dio_pull});
        // Write-clear: enabled sources latch
        wr(A_DEN, 32'h0000_0008);
        wr(A_EEN, 32'h0000_0001);
        ev(20'h0000a, 4'h3);
        rd_chk("dio_stat", A_DIO, 32'h8);
        rd_chk("err_stat", A_ERR, 32'h1);
        rd_chk("dio_stat", A_DIO, 32'h8);
        wr(A_DIO, 32'h0000_0000);
        rd_chk("dio_stat", A_DIO, 32'h8);
        wr(A_DIO, 32'h0000_0008);
        rd_chk("dio_stat", A_DIO, 32'h0);
        // Read-clear: second read sees zero
        wr(A_CFG, 32'h0000_0002);
        ev(20'h00008, 4'h0);
        wr(A_ERR, 32'h0000_0001);
        rd_chk("dio_stat", A_DIO, 32'h8);
        rd_chk("dio_stat", A_DIO, 32'h0);
        rd_chk("err_stat", A_ERR, 32'h1);
        rd_chk("err_stat", A_ERR, 32'h0);
        dma(16'h1234, 16'h1234);
        wr(A_CFG, 32'h0000_0003);
        dma(16'hbeef, 16'hefbe);
        rd_chk("cfg", A_CFG, 32'h3);
        // Mid-run reset, pulls back to floating
        do_reset();
        final_report();
    end

    // Hang guard, well beyond the run
    initial begin
        #20000;
        errors++;
        final_report();
    end
endmodule // tb
